// *** src/asp_pkg.sv ***
// Constants shared by the asynchronous serial port design
package asp_pkg;
  // Host byte ports on the board: data buffer and control/status location
  localparam logic [7:0] DATA_PORT_ADDR = 8'h18;
  localparam logic [7:0] CTRL_PORT_ADDR = 8'h1a;
  // Line format word field positions
  localparam int MODE_BAUD_LSB = 0;
  localparam int MODE_LEN_LSB = 2;
  localparam int MODE_PAR_ON_BIT = 4;
  localparam int MODE_PAR_EVEN_BIT = 5;
  localparam int MODE_STOP_LSB = 6;
  // Command word bit positions
  localparam int CMD_TX_EN_BIT = 0;
  localparam int CMD_DTR_BIT = 1;
  localparam int CMD_RX_EN_BIT = 2;
  localparam int CMD_BREAK_BIT = 3;
  localparam int CMD_ERR_CLR_BIT = 4;
  localparam int CMD_RTS_BIT = 5;
  localparam int CMD_FORMAT_BIT = 6;
  // Status word bit positions
  localparam int ST_TX_FREE_BIT = 0;
  localparam int ST_RX_AVAIL_BIT = 1;
  localparam int ST_TX_DRAINED_BIT = 2;
  localparam int ST_PAR_ERR_BIT = 3;
  localparam int ST_OVERRUN_BIT = 4;
  localparam int ST_FRAME_ERR_BIT = 5;
  localparam int ST_DSR_BIT = 7;
  // Baud factor codes and factors
  localparam logic [1:0] BAUD_SYNC = 2'h0;
  localparam logic [1:0] BAUD_X1 = 2'h1;
  localparam logic [1:0] BAUD_X16 = 2'h2;
  localparam logic [6:0] FACTOR_X1 = 7'h01;
  localparam logic [6:0] FACTOR_X16 = 7'h10;
  localparam logic [6:0] FACTOR_X64 = 7'h40;
  // Stop bit codes
  localparam logic [1:0] STOP_ONE_HALF = 2'h2;
  localparam logic [1:0] STOP_TWO = 2'h3;
  // Character length base and reset values
  localparam logic [3:0] LEN_BASE = 4'h5;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
endpackage : asp_pkg

// *** src/asp_tx.sv ***
// Transmit serialiser for one asynchronous character
`timescale 1ns/1ps
`default_nettype none
module asp_tx #(
  parameter int FRAME_W = 12
) (
  // Clock, reset and bit clock enable
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  // Character and format
  input wire logic start_in,
  input wire logic [7:0] data_in,
  input wire logic [6:0] factor_in,
  input wire logic [3:0] len_in,
  input wire logic par_on_in,
  input wire logic par_even_in,
  input wire logic [1:0] stop_in,
  // Line side
  output logic busy_out,
  output logic line_out
);
  if (FRAME_W < 12) $error("asp_tx: FRAME_W must be at least 12");
  logic [FRAME_W-1:0] shift_q;
  logic [3:0] bits_q;
  logic [6:0] ticks_q;
  logic half_q;
  logic [FRAME_W-1:0] frame;
  logic [3:0] nbits;
  logic par_bit;
  // Frame build: start, data LSB first, optional parity, stop ones
  always_comb
  begin
    frame = '1;
    frame[0] = 1'b0;
    par_bit = ~par_even_in;
    for (int i = 0; i < 8; i++)
    begin
      if (i < int'(len_in))
      begin
        frame[i+1] = data_in[i]; // RULE_10
        par_bit = par_bit ^ data_in[i];
      end
    end
    if (par_on_in)
      frame[len_in+4'h1] = par_bit; // RULE_09
    nbits = 4'h2 + len_in + {3'h0, par_on_in} + {3'h0, stop_in == asp_pkg::STOP_TWO};
  end
  // Bit timing: last stop bit stretched by half a bit for one and a half
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      shift_q <= '1;
      bits_q <= 4'h0;
      ticks_q <= 7'h00;
      half_q <= 1'b0;
      busy_out <= 1'b0;
    end
    else if (start_in && !busy_out)
    begin
      shift_q <= frame;
      bits_q <= nbits;
      ticks_q <= factor_in;
      half_q <= (stop_in == asp_pkg::STOP_ONE_HALF); // RULE_23
      busy_out <= 1'b1;
    end
    else if (busy_out && tick_in)
    begin
      if (ticks_q > 7'h01)
        ticks_q <= ticks_q - 7'h01;
      else
      begin
        shift_q <= {1'b1, shift_q[FRAME_W-1:1]};
        bits_q <= bits_q - 4'h1;
        ticks_q <= (bits_q == 4'h2 && half_q) ? factor_in + (factor_in >> 1) : factor_in;
        busy_out <= (bits_q != 4'h1);
      end
    end
  end
  assign line_out = busy_out ? shift_q[0] : 1'b1; // RULE_18
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  line_idle_a: assert property (!busy_out |-> line_out) else $error("line not idle high"); // RULE_18
  start_low_a: assert property (start_in && !busy_out |=> !line_out) else $error("no start bit"); // RULE_18
endmodule : asp_tx
`default_nettype wire

// *** src/asp_rx.sv ***
// Receive deserialiser with mid-bit sampling
`timescale 1ns/1ps
`default_nettype none
module asp_rx (
  // Clock, reset and bit clock enable
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic enable_in,
  // Line and format
  input wire logic line_in,
  input wire logic [6:0] factor_in,
  input wire logic [3:0] len_in,
  input wire logic par_on_in,
  input wire logic par_even_in,
  // Character out
  output logic done_out,
  output logic [7:0] data_out,
  output logic par_err_out,
  output logic frame_err_out
);
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_BITS = 4'b0100,
    RX_STOP = 4'b1000
  } asp_rx_state_t;
  asp_rx_state_t state_q;
  logic [6:0] ticks_q;
  logic [3:0] cnt_q;
  logic [8:0] shift_q;
  logic line_q;
  wire [3:0] nbits = len_in + {3'h0, par_on_in};
  wire [8:0] aligned = shift_q >> (4'h9 - nbits);
  wire [7:0] mask = 8'hff >> (4'h8 - len_in);
  wire [7:0] char_d = aligned[7:0] & mask; // RULE_10
  wire par_rx = aligned[len_in];
  // Sequencer: falling edge, half bit to centre, then whole bits
  always_ff @(posedge clock_in)
  begin
    done_out <= 1'b0;
    if (!rst_n_in || !enable_in)
    begin
      state_q <= RX_IDLE; // RULE_14
      ticks_q <= 7'h00;
      cnt_q <= 4'h0;
      shift_q <= 9'h000;
      line_q <= 1'b1;
      data_out <= 8'h00;
      par_err_out <= 1'b0;
      frame_err_out <= 1'b0;
    end
    else if (tick_in)
    begin
      line_q <= line_in;
      case (state_q)
        RX_IDLE:
          if (line_q && !line_in)
          begin
            state_q <= RX_START; // RULE_18
            // The check itself takes a tick, so wait half a bit less one
            ticks_q <= (factor_in >> 1) - {6'h00, factor_in[6:1] != 6'h00}; // RULE_18
          end
        RX_START:
          if (ticks_q != 7'h00)
            ticks_q <= ticks_q - 7'h01;
          else if (!line_in)
          begin
            state_q <= RX_BITS;
            ticks_q <= factor_in - 7'h01;
            cnt_q <= 4'h0;
          end
          else
            state_q <= RX_IDLE;
        RX_BITS:
          if (ticks_q != 7'h00)
            ticks_q <= ticks_q - 7'h01;
          else
          begin
            shift_q <= {line_in, shift_q[8:1]};
            cnt_q <= cnt_q + 4'h1;
            ticks_q <= factor_in - 7'h01;
            if (cnt_q + 4'h1 == nbits)
              state_q <= RX_STOP; // RULE_09
          end
        RX_STOP:
          if (ticks_q != 7'h00)
            ticks_q <= ticks_q - 7'h01;
          else
          begin
            state_q <= RX_IDLE;
            done_out <= 1'b1;
            data_out <= char_d;
            par_err_out <= par_on_in & ((^char_d) ^ par_rx ^ ~par_even_in); // RULE_08
            frame_err_out <= ~line_in;
          end
        default:
          state_q <= RX_IDLE;
      endcase
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  upper_zero_a: assert property (done_out |-> (data_out & ~mask) == 8'h00) else $error("upper bits set"); // RULE_10
endmodule : asp_rx
`default_nettype wire

// *** src/asp_serial_port.sv ***
// Asynchronous serial port: host byte port, format and command words, status
// Overview of operation
// RULE_01: Select line low picks character buffer, high picks control/status; board ports 18, 1A.
// RULE_02: Reset puts the port idle; command internal reset does the same.
// RULE_03: First control write after any reset is the format word; later ones commands.
// RULE_04: Host writes 00 three times, then 40, then the format word.
// RULE_05: Command bit 6 returns to awaiting a format word; host keeps it clear.
// RULE_06: Format bits 1:0 give bit clock factor: sync, x1, x16, x64.
// RULE_07: Format bits 3:2 give five to eight data bits.
// RULE_08: Format bit 4 enables parity; bit 5 picks even when set, odd when clear.
// RULE_09: Parity bit travels in addition to the data bits.
// RULE_10: Short characters read zeros above; transmitter ignores unused upper bits.
// RULE_11: Command bit 1 drives terminal ready, bit 5 request to send; 1 gives low.
// RULE_12: Command bit 3 holds the serial output low for a break.
// RULE_13: Transmit free shows only with transmit enable set and clear-to-send low.
// RULE_14: Characters are received only while receive enable is set.
// RULE_15: Status bits 0, 1, 2: transmit free, character waiting, transmitter drained.
// RULE_16: Status bits 3, 4, 5: parity, overrun, framing errors; reception continues.
// RULE_17: Status bit 7 reads the data-set-ready pin inverted.
// RULE_18: Output idles high; start bit low; receiver samples at bit centres.
// RULE_19: Enabled transmitter sends a written byte; held while clear-to-send is high.
// RULE_20: Complete character raises character waiting; reading the buffer clears it.
// RULE_21: Device clock must run above thirty times the baud rate.
// RULE_22: Drained output is high whenever no character waits or shifts.
// RULE_23: Format bits 7:6 give stop bits: invalid, one, one and a half, two.
// RULE_24: Command bit 4 clears parity, overrun and framing error flags.
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Host byte port
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic cd_sel_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n_out,
  // Serial line and bit clock enable
  input wire logic sample_tick_in,
  input wire logic rxd_in,
  output logic txd_out,
  // Modem handshakes
  input wire logic cts_n_in,
  input wire logic dsr_n_in,
  output logic dtr_n_out,
  output logic rts_n_out,
  // Indications
  output logic transmit_holding_free_out,
  output logic receive_char_available_out,
  output logic transmit_all_drained_out
);
  // Host strobe tracking
  logic wr_act_q;
  logic rd_act_q;
  logic rd_was_data_q;
  logic [7:0] read_data_q;
  // Format and command state
  logic soft_rst_q;
  logic expect_mode_q;
  logic [7:0] mode_q;
  logic [7:0] cmd_q;
  // Transmit holding buffer
  logic [7:0] hold_q;
  logic hold_full_q;
  // Receive buffer and error flags
  logic [7:0] rx_char_q;
  logic rx_ready_q;
  logic par_err_q;
  logic overrun_q;
  logic frame_err_q;
  // Submodule outputs
  logic tx_busy;
  logic tx_line;
  logic rx_done;
  logic [7:0] rx_char;
  logic rx_par_err;
  logic rx_frame_err;

  // Strobe decode: a write is taken once, a read acts at its end
  wire wr_act = !cs_n_in && !wr_n_in;
  wire rd_act = !cs_n_in && !rd_n_in;
  wire wr_pulse = wr_act && !wr_act_q;
  wire rd_start = rd_act && !rd_act_q;
  wire rd_end = rd_act_q && !rd_act;
  wire data_wr = wr_pulse && !cd_sel_in; // RULE_01
  wire ctrl_wr = wr_pulse && cd_sel_in; // RULE_01
  wire data_rd_end = rd_end && rd_was_data_q;

  // Internal reset shares the external reset path
  wire core_rst_n = rst_n_in && !soft_rst_q; // RULE_02
  wire cmd_wr = ctrl_wr && !expect_mode_q; // RULE_03
  wire soft_rst_req = cmd_wr && data_in[asp_pkg::CMD_FORMAT_BIT]; // RULE_05
  wire err_clr = cmd_wr && data_in[asp_pkg::CMD_ERR_CLR_BIT]; // RULE_24

  // Format word decode
  wire [1:0] baud_code = mode_q[asp_pkg::MODE_BAUD_LSB +: 2];
  wire [3:0] char_len = asp_pkg::LEN_BASE + {2'h0, mode_q[asp_pkg::MODE_LEN_LSB +: 2]}; // RULE_07
  wire par_on = mode_q[asp_pkg::MODE_PAR_ON_BIT]; // RULE_08
  wire par_even = mode_q[asp_pkg::MODE_PAR_EVEN_BIT]; // RULE_08
  wire [1:0] stop_code = mode_q[asp_pkg::MODE_STOP_LSB +: 2]; // RULE_23
  wire async_ok = (baud_code != asp_pkg::BAUD_SYNC);
  wire [6:0] factor = (baud_code == asp_pkg::BAUD_X1) ? asp_pkg::FACTOR_X1 :
                      (baud_code == asp_pkg::BAUD_X16) ? asp_pkg::FACTOR_X16 :
                      asp_pkg::FACTOR_X64; // RULE_06

  // Command word decode
  wire tx_en = cmd_q[asp_pkg::CMD_TX_EN_BIT];
  wire rx_en = cmd_q[asp_pkg::CMD_RX_EN_BIT] && async_ok; // RULE_14
  wire send_break = cmd_q[asp_pkg::CMD_BREAK_BIT];

  // Transmit hand-off: held byte goes out only with clear-to-send low
  wire tx_free = !hold_full_q && tx_en && !cts_n_in; // RULE_13
  wire tx_start = hold_full_q && tx_en && !cts_n_in && !tx_busy && async_ok; // RULE_19
  wire tx_drained = !hold_full_q && !tx_busy; // RULE_22
  wire overrun_evt = rx_done && rx_ready_q && !data_rd_end; // RULE_16

  // Status word assembly
  logic [7:0] status_word;
  always_comb
  begin
    status_word = 8'h00;
    status_word[asp_pkg::ST_TX_FREE_BIT] = tx_free; // RULE_15
    status_word[asp_pkg::ST_RX_AVAIL_BIT] = rx_ready_q; // RULE_15
    status_word[asp_pkg::ST_TX_DRAINED_BIT] = tx_drained; // RULE_15
    status_word[asp_pkg::ST_PAR_ERR_BIT] = par_err_q; // RULE_16
    status_word[asp_pkg::ST_OVERRUN_BIT] = overrun_q; // RULE_16
    status_word[asp_pkg::ST_FRAME_ERR_BIT] = frame_err_q; // RULE_16
    status_word[asp_pkg::ST_DSR_BIT] = !dsr_n_in; // RULE_17
  end

  // Host strobe history and read data capture
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      rd_was_data_q <= 1'b0;
      read_data_q <= 8'h00;
    end
    else
    begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (rd_start)
      begin
        rd_was_data_q <= !cd_sel_in;
        read_data_q <= cd_sel_in ? status_word : rx_char_q; // RULE_01
      end
    end
  end

  // Internal reset request lasts one cycle
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= soft_rst_req; // RULE_02
  end

  // Format word first after reset, commands afterwards
  always_ff @(posedge clock_in)
  begin
    if (!core_rst_n)
    begin
      expect_mode_q <= 1'b1; // RULE_03
      mode_q <= asp_pkg::MODE_RESET;
      cmd_q <= asp_pkg::CMD_RESET;
    end
    else if (ctrl_wr && expect_mode_q)
    begin
      mode_q <= data_in; // RULE_03
      expect_mode_q <= 1'b0;
    end
    else if (cmd_wr)
      cmd_q <= data_in; // RULE_03
  end

  // Transmit holding register
  always_ff @(posedge clock_in)
  begin
    if (!core_rst_n)
    begin
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
    end
    else if (data_wr)
    begin
      hold_q <= data_in;
      hold_full_q <= 1'b1; // RULE_19
    end
    else if (tx_start)
      hold_full_q <= 1'b0;
  end

  // Receive buffer: new character wins over a read clearing it
  always_ff @(posedge clock_in)
  begin
    if (!core_rst_n)
    begin
      rx_char_q <= 8'h00;
      rx_ready_q <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_char_q <= rx_char;
      rx_ready_q <= 1'b1; // RULE_20
    end
    else if (data_rd_end)
      rx_ready_q <= 1'b0; // RULE_20
  end

  // Error flags: a new error wins over the clear command
  always_ff @(posedge clock_in)
  begin
    if (!core_rst_n)
    begin
      par_err_q <= 1'b0;
      overrun_q <= 1'b0;
      frame_err_q <= 1'b0;
    end
    else
    begin
      par_err_q <= (par_err_q && !err_clr) || (rx_done && rx_par_err); // RULE_16
      overrun_q <= (overrun_q && !err_clr) || overrun_evt; // RULE_16
      frame_err_q <= (frame_err_q && !err_clr) || (rx_done && rx_frame_err); // RULE_24
    end
  end

  // Transmit serialiser
  asp_tx #(
    .FRAME_W(12)
  ) u_tx (
    .clock_in(clock_in),
    .rst_n_in(core_rst_n),
    .tick_in(sample_tick_in),
    .start_in(tx_start),
    .data_in(hold_q),
    .factor_in(factor),
    .len_in(char_len),
    .par_on_in(par_on),
    .par_even_in(par_even),
    .stop_in(stop_code),
    .busy_out(tx_busy),
    .line_out(tx_line)
  );

  // Receive deserialiser
  asp_rx u_rx (
    .clock_in(clock_in),
    .rst_n_in(core_rst_n),
    .tick_in(sample_tick_in),
    .enable_in(rx_en),
    .line_in(rxd_in),
    .factor_in(factor),
    .len_in(char_len),
    .par_on_in(par_on),
    .par_even_in(par_even),
    .done_out(rx_done),
    .data_out(rx_char),
    .par_err_out(rx_par_err),
    .frame_err_out(rx_frame_err)
  );

  // Pin and indication drive
  assign txd_out = send_break ? 1'b0 : tx_line; // RULE_12
  assign dtr_n_out = !cmd_q[asp_pkg::CMD_DTR_BIT]; // RULE_11
  assign rts_n_out = !cmd_q[asp_pkg::CMD_RTS_BIT]; // RULE_11
  assign data_out = read_data_q;
  assign data_oe_n_out = !rd_act_q;
  assign transmit_holding_free_out = tx_free;
  assign receive_char_available_out = rx_ready_q;
  assign transmit_all_drained_out = tx_drained;

  // Checks on the finished behaviour
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence mode_wr_s;
    ctrl_wr && expect_mode_q;
  endsequence

  sequence force_format_s;
    cmd_wr && data_in[asp_pkg::CMD_FORMAT_BIT];
  endsequence

  format_taken_a: assert property ( // RULE_03
    mode_wr_s |=> !expect_mode_q && mode_q == $past(data_in))
    else $error("format word not taken");

  internal_reset_a: assert property ( // RULE_05
    force_format_s |=> soft_rst_q ##1 expect_mode_q && cmd_q == asp_pkg::CMD_RESET)
    else $error("internal reset did not return to format");

  tx_ready_gate_a: assert property ( // RULE_13
    transmit_holding_free_out |-> tx_en && !cts_n_in)
    else $error("transmit free without enable and clear-to-send");

  send_hold_a: assert property ( // RULE_19
    hold_full_q && cts_n_in |=> hold_full_q)
    else $error("byte left holding while clear-to-send high");

  break_low_a: assert property ( // RULE_12
    send_break |-> !txd_out)
    else $error("break not holding line low");

  drained_write_a: assert property ( // RULE_22
    data_wr |=> !transmit_all_drained_out)
    else $error("drained while a byte is held");

  read_clear_a: assert property ( // RULE_20
    data_rd_end && !rx_done |=> !receive_char_available_out)
    else $error("read did not clear character waiting");

  overrun_set_a: assert property ( // RULE_16
    rx_done && rx_ready_q && !data_rd_end |=> overrun_q)
    else $error("overrun not flagged");

  err_clear_a: assert property ( // RULE_24
    err_clr && !rx_done |=> !par_err_q && !overrun_q && !frame_err_q)
    else $error("error flags not cleared");

  dsr_status_a: assert property ( // RULE_17
    rd_start && cd_sel_in |=> data_out[asp_pkg::ST_DSR_BIT] == !$past(dsr_n_in))
    else $error("status bit 7 does not follow data-set-ready");

  rx_off_a: assert property ( // RULE_14
    !rx_en && !rx_ready_q |=> !rx_ready_q)
    else $error("character received while disabled");

  modem_out_a: assert property ( // RULE_11
    cmd_wr && !data_in[asp_pkg::CMD_FORMAT_BIT] |=> dtr_n_out == !$past(data_in[1]))
    else $error("terminal ready pin does not follow command");
endmodule : asp_serial_port
`default_nettype wire

// *** dv/asp_remote_model.sv ***
// Far-end serial device model: frames the receive line, decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module asp_remote_model #(
  parameter int BIT_CLKS = 32
) (
  // Device clock
  input wire logic clock_in,
  // Serial line and handshakes
  input wire logic txd_in,
  output logic rxd_out,
  output logic cts_n_out,
  output logic dsr_n_out
);
  // Idle line high, clear to send granted, data set not ready
  initial
  begin
    rxd_out = 1'b1;
    cts_n_out = 1'b0;
    dsr_n_out = 1'b1;
  end

  // Start bit, then n bits LSB first, then one bit time of idle
  task automatic send(input logic [9:0] bits, input int n);
    rxd_out = 1'b0;
    repeat (BIT_CLKS) @(negedge clock_in);
    for (int i = 0; i < n; i++)
    begin
      rxd_out = bits[i];
      repeat (BIT_CLKS) @(negedge clock_in);
    end
    rxd_out = 1'b1;
    repeat (BIT_CLKS) @(negedge clock_in);
  endtask : send

  // Sample n bits after the start bit, each at its bit centre
  task automatic get(input int n, output logic [9:0] bits);
    bits = 10'h000;
    @(negedge txd_in);
    repeat (BIT_CLKS / 2) @(negedge clock_in);
    for (int i = 0; i < n; i++)
    begin
      repeat (BIT_CLKS) @(negedge clock_in);
      bits[i] = txd_in;
    end
  endtask : get
endmodule : asp_remote_model
`default_nettype wire

// *** dv/tb_asp_serial_port.sv ***
// Self-checking bench for the asynchronous serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h got %h", nm, e, a); end end
module tb_asp_serial_port;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic cd = 1'b0;
  logic [7:0] din = 8'h00;
  logic tick = 1'b0;
  wire logic rxd, txd, cts_n, dsr_n, dtr_n, rts_n, free, avail, drained, oe_n;
  wire logic [7:0] dout;
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] st;
  logic [9:0] fr;

  // Clock, and a bit clock pulse every two cycles: x16 gives 32 cycles a bit
  always #25 clock_in = ~clock_in;
  always @(negedge clock_in) tick <= ~tick;

  // Device and far-end model
  asp_serial_port asp_serial_port_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .cd_sel_in(cd), .data_in(din),
    .data_out(dout), .data_oe_n_out(oe_n), .sample_tick_in(tick), .rxd_in(rxd),
    .txd_out(txd), .cts_n_in(cts_n), .dsr_n_in(dsr_n), .dtr_n_out(dtr_n),
    .rts_n_out(rts_n), .transmit_holding_free_out(free),
    .receive_char_available_out(avail), .transmit_all_drained_out(drained));
  asp_remote_model asp_remote_model_inst (.clock_in(clock_in), .txd_in(txd),
    .rxd_out(rxd), .cts_n_out(cts_n), .dsr_n_out(dsr_n));

  // Host write cycle with one idle cycle after
  task automatic wr(input logic c, input logic [7:0] d);
    @(negedge clock_in);
    cs_n = 1'b0;
    wr_n = 1'b0;
    cd = c;
    din = d;
    @(negedge clock_in);
    cs_n = 1'b1;
    wr_n = 1'b1;
    @(negedge clock_in);
  endtask : wr

  // Host read cycle: data taken two cycles after the strobe
  task automatic rd(input logic c, output logic [7:0] d);
    @(negedge clock_in);
    cs_n = 1'b0;
    rd_n = 1'b0;
    cd = c;
    repeat (2) @(negedge clock_in);
    d = dout;
    `CHK("oe_n", 1'b0, oe_n)
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (2) @(negedge clock_in);
    `CHK("oe_n", 1'b1, oe_n)
  endtask : rd

  // Wait, bounded, until the transmitter is drained
  task automatic wait_drained();
    for (int i = 0; i < 400 && drained !== 1'b1; i++) @(negedge clock_in);
    `CHK("drained", 1'b1, drained)
  endtask : wait_drained

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // Outputs and status straight after reset
  task automatic t_reset();
    `CHK("txd", 1'b1, txd)
    `CHK("dtr_n", 1'b1, dtr_n)
    `CHK("rts_n", 1'b1, rts_n)
    `CHK("free", 1'b0, free)
    rd(1'b1, st);
    `CHK("status", 8'h04, st & 8'hbf)
  endtask : t_reset

  // Safe start sequence, format word, then enable both directions
  task automatic t_init(input logic [7:0] fmt);
    repeat (3) wr(1'b1, 8'h00);
    wr(1'b1, 8'h40);
    wr(1'b1, fmt);
    wr(1'b1, 8'h27);
    `CHK("dtr_n", 1'b0, dtr_n)
    `CHK("rts_n", 1'b0, rts_n)
    `CHK("free", 1'b1, free)
    rd(1'b1, st);
    `CHK("status", 8'h05, st & 8'hbf)
  endtask : t_init

  // Write one byte and decode the frame on the line
  task automatic t_tx(input logic [7:0] d, input int n, input logic [9:0] e);
    fork
      begin
        wr(1'b0, d);
        `CHK("drained", 1'b0, drained)
      end
      asp_remote_model_inst.get(n, fr);
    join
    `CHK("frame", e, fr)
    wait_drained();
  endtask : t_tx

  // Send one frame, check error flags, read the byte
  task automatic t_rx(input logic [9:0] b, input int n, input logic [7:0] d,
    input logic [7:0] err);
    asp_remote_model_inst.send(b, n);
    `CHK("avail", 1'b1, avail)
    rd(1'b1, st);
    `CHK("errors", err, st & 8'h38)
    rd(1'b0, st);
    `CHK("rx data", d, st)
    `CHK("avail", 1'b0, avail)
  endtask : t_rx

  // Errors, overrun, then flag clear by command
  task automatic t_errors();
    t_rx({2'b11, 1'b0, 7'h2a}, 9, 8'h2a, 8'h08);
    t_rx({2'b10, 1'b1, 7'h2a}, 9, 8'h2a, 8'h28);
    asp_remote_model_inst.send({2'b11, 1'b1, 7'h2a}, 9);
    t_rx({2'b11, 1'b1, 7'h15}, 9, 8'h15, 8'h38);
    wr(1'b1, 8'h37);
    t_rx({2'b11, 1'b1, 7'h2a}, 9, 8'h2a, 8'h00);
  endtask : t_errors

  // Clear to send withdrawn: byte held until granted
  task automatic t_cts();
    asp_remote_model_inst.cts_n_out = 1'b1;
    @(negedge clock_in);
    `CHK("free", 1'b0, free)
    fork
      begin
        wr(1'b0, 8'h5a);
        repeat (100) @(negedge clock_in);
        `CHK("txd", 1'b1, txd)
        `CHK("drained", 1'b0, drained)
        asp_remote_model_inst.cts_n_out = 1'b0;
      end
      asp_remote_model_inst.get(10, fr);
    join
    `CHK("frame", {2'b11, 1'b0, 7'h5a}, fr)
    wait_drained();
  endtask : t_cts

  // Break, data set ready, receiver disabled
  task automatic t_misc();
    wr(1'b1, 8'h2f);
    repeat (50) @(negedge clock_in);
    `CHK("break", 1'b0, txd)
    wr(1'b1, 8'h27);
    `CHK("txd", 1'b1, txd)
    asp_remote_model_inst.dsr_n_out = 1'b0;
    rd(1'b1, st);
    `CHK("dsr", 1'b1, st[7])
    asp_remote_model_inst.dsr_n_out = 1'b1;
    rd(1'b1, st);
    `CHK("dsr", 1'b0, st[7])
    wr(1'b1, 8'h23);
    asp_remote_model_inst.send({2'b11, 1'b1, 7'h2a}, 9);
    `CHK("avail", 1'b0, avail)
  endtask : t_misc

  // Internal reset, then a 5-bit odd-parity format both ways
  task automatic t_soft();
    wr(1'b1, 8'h40);
    `CHK("dtr_n", 1'b1, dtr_n)
    wr(1'b1, 8'h52);
    wr(1'b1, 8'h27);
    `CHK("dtr_n", 1'b0, dtr_n)
    t_tx(8'hff, 7, 10'h05f);
    t_rx({2'b11, 1'b0, 7'h5f}, 7, 8'h1f, 8'h00);
  endtask : t_soft

  // External reset mid-run, then eight data bits, no parity, one and a half stops
  task automatic t_eight();
    @(negedge clock_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clock_in);
    rst_n_in = 1'b1;
    t_reset();
    t_init(8'h8e);
    t_tx(8'ha5, 9, 10'h1a5);
    t_rx(10'h13c, 9, 8'h3c, 8'h00);
  endtask : t_eight

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clock_in);
    @(negedge clock_in);
    rst_n_in = 1'b1;
    t_reset();
    t_init(8'hfa);
    t_tx(8'hd5, 10, {2'b11, 1'b0, 7'h55});
    t_errors();
    t_cts();
    t_misc();
    t_soft();
    t_eight();
    report_and_stop();
  end

  // Watchdog
  initial
  begin
    #1000000;
    error_cnt++;
    $display("Error watchdog expired");
    report_and_stop();
  end
endmodule : tb_asp_serial_port
`default_nettype wire
